// >>> hw/etb_pkg.sv
package etb_pkg;

    // ----------------------------------------------------------------
    // Background access-space codes
    // ----------------------------------------------------------------
    localparam logic [2:0] ETB_FC_SUP_DATA = 3'h5;
    localparam logic [2:0] ETB_FC_USR_PROG = 3'h2;
    localparam logic [2:0] ETB_FC_USR_DATA = 3'h1;
    localparam logic [2:0] ETB_FC_SUP_PROG = 3'h6;

    // ----------------------------------------------------------------
    // Clock figures
    // ----------------------------------------------------------------
    localparam int ETB_INT_OSC_KHZ = 16000;
    localparam int ETB_EXT_MAX_KHZ = 16670;
    localparam int ETB_CORE_CLK_KHZ = 125000;
    // Core cycles per internal oscillator half period, rounded down
    localparam int ETB_OSC_HALF_CYC = ETB_CORE_CLK_KHZ / (2 * ETB_INT_OSC_KHZ);

    // ----------------------------------------------------------------
    // Counts and widths
    // ----------------------------------------------------------------
    localparam int ETB_NUM_CS = 4;
    localparam int ETB_BLK_W = 8;
    localparam logic [7:0] ETB_BLK_RESET = 8'h00;
    localparam logic [2:0] ETB_PRIO_NONE = 3'h7;

    // ----------------------------------------------------------------
    // Mode enumerations
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ETB_BG_SP,
        ETB_BG_SD,
        ETB_BG_UP,
        ETB_BG_UD
    } etb_bg_code_t;

    // Configuration word gathered into one carrier
    typedef struct packed {
        etb_bg_code_t bg_code;
        logic [7:0] bg_block;
        logic drive_bg;
        logic ack_interlock;
        logic bus_error_response;
        logic clk_internal;
        logic shared_pin_function;
        logic interrupt_input_mode;
        logic top_request_trigger_mode;
        logic [3:0] chip_select_ack_source;
    } etb_cfg_t;

    // Processor-side bus cycle description
    typedef struct packed {
        logic active;
        logic background;
        logic foreground_mon;
        logic emul_mem;
        logic internal_ack;
        logic write;
        logic [2:0] space;
        logic [7:0] addr_hi;
    } etb_cycle_t;

endpackage

// >>> hw/etb_clk_sel.sv
`timescale 1ns/1ps
`default_nettype none
module etb_clk_sel
    import etb_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic clk_internal_in,
    input wire logic clk_select_strobe_in,
    input wire logic probe_clk_in,
    input wire logic reset_release_in,
    output logic emu_clk_out,
    output logic emu_reset_out
);
    // Phase accumulator: twice the oscillator rate added per core cycle
    localparam int CW = 18;
    localparam logic [CW-1:0] STEP = CW'(2 * ETB_INT_OSC_KHZ);
    localparam logic [CW-1:0] LIM = CW'(ETB_CORE_CLK_KHZ);

    logic [CW-1:0] div_cnt;
    logic [CW-1:0] next_div_cnt;
    logic [CW-1:0] acc_sum;
    logic osc;
    logic next_osc;
    logic hold;
    logic next_hold;

    // ----------------------------------------------------------------
    // Next state of divider and reset hold
    // ----------------------------------------------------------------
    always_comb begin
        next_div_cnt = div_cnt;
        next_osc = osc;
        next_hold = hold;
        acc_sum = div_cnt + STEP;
        if (acc_sum >= LIM) begin
            next_div_cnt = acc_sum - LIM;
            next_osc = ~osc;
        end else begin
            next_div_cnt = acc_sum;
        end
        if (clk_select_strobe_in && clk_internal_in) begin
            next_hold = 1'b1;
        end else if (reset_release_in) begin
            next_hold = 1'b0;
        end
    end

    // Registers
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            div_cnt <= '0;
            osc <= 1'b0;
            hold <= 1'b0;
        end else if (ce_in) begin
            div_cnt <= next_div_cnt;
            osc <= next_osc;
            hold <= next_hold;
        end
    end

    // Source choice
    assign emu_clk_out = clk_internal_in ? osc : probe_clk_in;
    assign emu_reset_out = hold;

    a_hold_on_select: assert property (@(posedge core_clk_in) disable iff (rst_in)
        ce_in && clk_select_strobe_in && clk_internal_in |=> emu_reset_out)
        else $error("reset not held after internal clock select");
endmodule
`default_nettype wire

// >>> hw/etb_irq_route.sv
`timescale 1ns/1ps
`default_nettype none
module etb_irq_route
    import etb_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic interrupt_input_mode_in,
    input wire logic top_request_trigger_mode_in,
    input wire logic priority_line_top_in,
    input wire logic priority_line_mid_in,
    input wire logic priority_line_low_in,
    output logic [2:0] irq_level_out,
    output logic [2:0] irq_dedicated_out
);
    logic top_q;
    logic next_top_q;
    logic edge_seen;
    logic next_edge_seen;
    logic [2:0] lvl;
    logic [2:0] next_lvl;
    logic [2:0] ded;
    logic [2:0] next_ded;

    // ----------------------------------------------------------------
    // Decode of the three priority lines
    // ----------------------------------------------------------------
    always_comb begin
        next_top_q = priority_line_top_in;
        next_edge_seen = top_q && !priority_line_top_in;
        next_lvl = 3'h0;
        next_ded = 3'h0;
        if (!interrupt_input_mode_in) begin
            next_lvl = ~{priority_line_top_in, priority_line_mid_in, priority_line_low_in};
        end else begin
            // Bit2 request 7, bit1 request 6, bit0 request 1
            next_ded[1] = !priority_line_mid_in;
            next_ded[0] = !priority_line_low_in;
            next_ded[2] = top_request_trigger_mode_in ? next_edge_seen
                                                      : !priority_line_top_in;
        end
    end

    // Registers
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            top_q <= 1'b1;
            edge_seen <= 1'b0;
            lvl <= 3'h0;
            ded <= 3'h0;
        end else if (ce_in) begin
            top_q <= next_top_q;
            edge_seen <= next_edge_seen;
            lvl <= next_lvl;
            ded <= next_ded;
        end
    end

    assign irq_level_out = lvl;
    assign irq_dedicated_out = ded;

    a_edge_one_pulse: assert property (@(posedge core_clk_in) disable iff (rst_in)
        ce_in && interrupt_input_mode_in && top_request_trigger_mode_in
        && top_q && !priority_line_top_in |=> irq_dedicated_out[2])
        else $error("falling edge on top request not flagged");
endmodule
`default_nettype wire

// >>> hw/etb_target_bus.sv
`timescale 1ns/1ps
`default_nettype none
module etb_target_bus
    import etb_pkg::*;
#(
    parameter int NUM_CS = ETB_NUM_CS
)
(
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire etb_cfg_t cfg_in,
    input wire logic clk_select_strobe_in,
    input wire logic reset_release_in,
    input wire logic probe_clk_in,
    input wire logic target_present_in,
    input wire etb_cycle_t cyc_in,
    input wire logic [NUM_CS-1:0] cs_active_in,
    input wire logic [NUM_CS-1:0] cs_field_internal_in,
    input wire logic cpu_top_ack_in,
    input wire logic port_bit_zero_in,
    input wire logic cycle_ack_n_in,
    input wire logic bus_fault_n_in,
    input wire logic priority_line_top_in,
    input wire logic priority_line_mid_in,
    input wire logic priority_line_low_in,
    output logic emu_clk_out,
    output logic emu_reset_out,
    output logic tgt_drive_out,
    output logic tgt_write_out,
    output logic [2:0] access_space_code_out,
    output logic [7:0] tgt_addr_hi_out,
    output logic cycle_ack_n_out,
    output logic cycle_ack_n_oe_out,
    output logic cpu_ack_out,
    output logic cpu_bus_fault_out,
    output logic shared_pin_out,
    output logic [2:0] irq_level_out,
    output logic [2:0] irq_dedicated_out
);
    logic drive;
    logic next_drive;
    logic wr;
    logic next_wr;
    logic [2:0] space;
    logic [2:0] next_space;
    logic [7:0] addr_hi;
    logic [7:0] next_addr_hi;
    logic tgt_ack;
    logic next_tgt_ack;
    logic cpu_ack;
    logic next_cpu_ack;
    logic fault;
    logic next_fault;
    logic shpin;
    logic next_shpin;
    logic [2:0] bg_code;
    logic [NUM_CS-1:0] cs_int_hit;
    logic [NUM_CS-1:0] cs_ext_hit;
    logic any_int;
    logic any_ext;
    logic needs_ext;

    // ----------------------------------------------------------------
    // Clock source and reset hold
    // ----------------------------------------------------------------
    etb_clk_sel u_clk (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .clk_internal_in(cfg_in.clk_internal),
        .clk_select_strobe_in(clk_select_strobe_in),
        .probe_clk_in(probe_clk_in),
        .reset_release_in(reset_release_in),
        .emu_clk_out(emu_clk_out),
        .emu_reset_out(emu_reset_out)
    );

    // ----------------------------------------------------------------
    // Interrupt input routing
    // ----------------------------------------------------------------
    etb_irq_route u_irq (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .interrupt_input_mode_in(cfg_in.interrupt_input_mode),
        .top_request_trigger_mode_in(cfg_in.top_request_trigger_mode),
        .priority_line_top_in(priority_line_top_in),
        .priority_line_mid_in(priority_line_mid_in),
        .priority_line_low_in(priority_line_low_in),
        .irq_level_out(irq_level_out),
        .irq_dedicated_out(irq_dedicated_out)
    );

    // Background code table
    always_comb begin
        case (cfg_in.bg_code)
            ETB_BG_SP: bg_code = ETB_FC_SUP_PROG;
            ETB_BG_SD: bg_code = ETB_FC_SUP_DATA;
            ETB_BG_UP: bg_code = ETB_FC_USR_PROG;
            ETB_BG_UD: bg_code = ETB_FC_USR_DATA;
            default: bg_code = ETB_FC_SUP_PROG;
        endcase
    end

    // ----------------------------------------------------------------
    // Per chip select acknowledge source
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_CS; g++) begin : g_cs
            // Internal ack only when field and emulator setting both ask
            assign cs_int_hit[g] = cs_active_in[g] && cs_field_internal_in[g]
                                   && cfg_in.chip_select_ack_source[g];
            assign cs_ext_hit[g] = cs_active_in[g] && !cs_int_hit[g];
        end
    endgenerate
    assign any_int = |cs_int_hit;
    assign any_ext = |cs_ext_hit;
    // Cycles that rely on an external acknowledge
    assign needs_ext = cyc_in.active && !cyc_in.internal_ack && !any_int;

    // ----------------------------------------------------------------
    // Next values of the target-facing and processor-side outputs
    // ----------------------------------------------------------------
    always_comb begin
        next_drive = 1'b0;
        next_wr = 1'b0;
        next_space = 3'h0;
        next_addr_hi = ETB_BLK_RESET;
        next_tgt_ack = 1'b0;
        next_cpu_ack = 1'b0;
        next_fault = 1'b0;
        if (cyc_in.active) begin
            if (cyc_in.background && !cyc_in.foreground_mon) begin
                if (cfg_in.drive_bg) begin
                    next_drive = 1'b1;
                    next_space = bg_code;
                    next_addr_hi = cfg_in.bg_block;
                    next_wr = 1'b0;
                end
                // Otherwise outputs stay idle
            end else begin
                next_drive = 1'b1;
                next_space = cyc_in.space;
                next_addr_hi = cyc_in.addr_hi;
                next_wr = cyc_in.write;
            end
        end
        // Internal chip select ack goes out to target only
        if (any_int) begin
            next_tgt_ack = 1'b1;
        end
        if (needs_ext && (any_ext || cyc_in.emul_mem || cyc_in.background)) begin
            if (!target_present_in) begin
                next_cpu_ack = 1'b1;
            end else if (cfg_in.ack_interlock) begin
                next_cpu_ack = !cycle_ack_n_in;
            end else if (cyc_in.emul_mem || cyc_in.background) begin
                next_cpu_ack = 1'b1;
            end else begin
                next_cpu_ack = !cycle_ack_n_in;
            end
        end
        // Bus fault only while connected
        if (cfg_in.bus_error_response && target_present_in && cyc_in.active
            && cyc_in.emul_mem && !bus_fault_n_in) begin
            next_fault = 1'b1;
            next_cpu_ack = 1'b0;
        end
    end

    // Shared pin
    always_comb begin
        if (cfg_in.shared_pin_function) begin
            next_shpin = 1'b0;
        end else begin
            next_shpin = port_bit_zero_in;
        end
    end

    // Registers
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            drive <= 1'b0;
            wr <= 1'b0;
            space <= 3'h0;
            addr_hi <= ETB_BLK_RESET;
            tgt_ack <= 1'b0;
            cpu_ack <= 1'b0;
            fault <= 1'b0;
            shpin <= 1'b0;
        end else if (ce_in) begin
            drive <= next_drive;
            wr <= next_wr;
            space <= next_space;
            addr_hi <= next_addr_hi;
            tgt_ack <= next_tgt_ack;
            cpu_ack <= next_cpu_ack;
            fault <= next_fault;
            shpin <= next_shpin;
        end
    end

    // Output assignments
    assign tgt_drive_out = drive;
    assign tgt_write_out = wr;
    assign access_space_code_out = space;
    assign tgt_addr_hi_out = addr_hi;
    assign cycle_ack_n_out = 1'b0;
    assign cycle_ack_n_oe_out = !tgt_ack;
    assign cpu_ack_out = cpu_ack;
    assign cpu_bus_fault_out = fault;
    assign shared_pin_out = shpin;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_bg_code_sd: assert property (@(posedge core_clk_in) disable iff (rst_in)
        ce_in && cyc_in.active && cyc_in.background && !cyc_in.foreground_mon
        && cfg_in.drive_bg && cfg_in.bg_code == ETB_BG_SD
        |=> access_space_code_out == 3'h5 && tgt_addr_hi_out == $past(cfg_in.bg_block))
        else $error("background code or block wrong");
    a_bg_code_sp: assert property (@(posedge core_clk_in) disable iff (rst_in)
        ce_in && cyc_in.active && cyc_in.background && !cyc_in.foreground_mon
        && cfg_in.drive_bg && cfg_in.bg_code == ETB_BG_SP
        |=> access_space_code_out == 3'h6)
        else $error("supervisor program code wrong");
    a_bg_read_only: assert property (@(posedge core_clk_in) disable iff (rst_in)
        ce_in && cyc_in.active && cyc_in.background && !cyc_in.foreground_mon
        && cfg_in.drive_bg |=> tgt_drive_out && !tgt_write_out)
        else $error("background write shown as write");
    a_bg_idle: assert property (@(posedge core_clk_in) disable iff (rst_in)
        ce_in && cyc_in.background && !cyc_in.foreground_mon && !cfg_in.drive_bg
        |=> !tgt_drive_out)
        else $error("background cycle driven while drive off");
    a_int_ack_out: assert property (@(posedge core_clk_in) disable iff (rst_in)
        ce_in && any_int |=> !cycle_ack_n_oe_out && !cpu_ack_out)
        else $error("internal ack not passed to target");
    a_interlock_wait: assert property (@(posedge core_clk_in) disable iff (rst_in)
        ce_in && needs_ext && cyc_in.emul_mem && target_present_in
        && cfg_in.ack_interlock && cycle_ack_n_in |=> !cpu_ack_out)
        else $error("emulation memory ended before target ack");
    a_no_target_ack: assert property (@(posedge core_clk_in) disable iff (rst_in)
        ce_in && needs_ext && cyc_in.emul_mem && !target_present_in
        |=> cpu_ack_out)
        else $error("no self ack without target");
    a_fault_gate: assert property (@(posedge core_clk_in) disable iff (rst_in)
        ce_in && !cfg_in.bus_error_response |=> !cpu_bus_fault_out)
        else $error("bus fault passed while disabled");
endmodule
`default_nettype wire

// >>> tb/etb_target_model.sv
`timescale 1ns/1ps
`default_nettype none
module etb_target_model (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic tgt_drive_in,
    input wire logic slow_in,
    input wire logic fault_in,
    output logic probe_clk_out,
    output logic cycle_ack_n_out,
    output logic bus_fault_n_out
);
    // ------------------------------
    // Target board behaviour
    // ------------------------------
    logic [1:0] wait_cnt;

    // Free running board clock, 60 ns period
    initial probe_clk_out = 1'b0;
    always #30 probe_clk_out = ~probe_clk_out;

    // Ack every driven cycle, promptly or after two waits; ack line pulled up when idle, fault line follows fault_in
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wait_cnt <= 2'h0;
            cycle_ack_n_out <= 1'b1;
            bus_fault_n_out <= 1'b1;
        end else begin
            bus_fault_n_out <= !fault_in;
            if (tgt_drive_in) begin
                if (wait_cnt >= (slow_in ? 2'h2 : 2'h0)) begin
                    cycle_ack_n_out <= 1'b0;
                end else begin
                    wait_cnt <= wait_cnt + 2'h1;
                end
            end else begin
                wait_cnt <= 2'h0;
                cycle_ack_n_out <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb/test_etb_target_bus.sv
`timescale 1ns/1ps
`default_nettype none
module test_etb_target_bus;
    import etb_pkg::*;
    // ------------------------------
    // Stimulus and observed signals
    // ------------------------------
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic strobe = 1'b0, rel = 1'b0, present = 1'b0, slow = 1'b0, fault = 1'b0;
    logic port_bit = 1'b0, top_ack = 1'b0, top = 1'b1, mid = 1'b1, low = 1'b1, prev_clk;
    logic [3:0] cs_act = 4'h0, cs_fld = 4'h0;
    etb_cfg_t cfg = '0;
    etb_cycle_t cyc = '0;
    logic probe_clk, ack_n, fault_n, emu_clk, emu_rst, drv, wr, oe, ack_out, cpu_ack, cpu_flt, pin;
    logic [2:0] space, lvl, ded;
    logic [7:0] addr;
    logic [31:0] seed = 32'h8336;
    logic [31:0] r;
    int n_errors = 0, tests_run = 0, hold = 0, valid = 0, quiet = 3, toggles, csi;
    int e_drv, e_wr, e_sp, e_ad, e_ack, e_oe, e_flt, e_lvl, e_ded, e_act, ack_ok, e_pin;
    int th[$];

    always #4 core_clk_in = ~core_clk_in;

    etb_target_bus i_etb_target_bus (.core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(1'b1),
        .cfg_in(cfg), .clk_select_strobe_in(strobe), .reset_release_in(rel),
        .probe_clk_in(probe_clk), .target_present_in(present), .cyc_in(cyc),
        .cs_active_in(cs_act), .cs_field_internal_in(cs_fld), .cpu_top_ack_in(top_ack),
        .port_bit_zero_in(port_bit), .cycle_ack_n_in(ack_n), .bus_fault_n_in(fault_n),
        .priority_line_top_in(top), .priority_line_mid_in(mid), .priority_line_low_in(low),
        .emu_clk_out(emu_clk), .emu_reset_out(emu_rst), .tgt_drive_out(drv),
        .tgt_write_out(wr), .access_space_code_out(space), .tgt_addr_hi_out(addr),
        .cycle_ack_n_out(ack_out), .cycle_ack_n_oe_out(oe), .cpu_ack_out(cpu_ack),
        .cpu_bus_fault_out(cpu_flt), .shared_pin_out(pin), .irq_level_out(lvl),
        .irq_dedicated_out(ded));

    etb_target_model i_etb_target_model (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .tgt_drive_in(drv), .slow_in(slow), .fault_in(fault), .probe_clk_out(probe_clk),
        .cycle_ack_n_out(ack_n), .bus_fault_n_out(fault_n));

    // ------------------------------
    // Helpers
    // ------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        if (n_errors == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------
    // Reference model, one result per edge
    // ------------------------------
    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            hold = 0;
            valid = 0;
            quiet = 3;
            th.delete();
        end else begin
            csi = |(cs_act & cs_fld & cfg.chip_select_ack_source);
            e_act = cyc.active;
            e_drv = cyc.active && (!cyc.background || cfg.drive_bg);
            e_wr = cyc.background ? 0 : cyc.write;
            case (cfg.bg_code)
                ETB_BG_SP: e_sp = 6;
                ETB_BG_SD: e_sp = 5;
                ETB_BG_UP: e_sp = 2;
                default: e_sp = 1;
            endcase
            if (!cyc.background) e_sp = cyc.space;
            e_ad = cyc.background ? cfg.bg_block : cyc.addr_hi;
            e_flt = cyc.emul_mem && cfg.bus_error_response && present && !fault_n;
            e_oe = !csi;
            if (csi || e_flt) e_ack = 0;
            else if (!(|(cs_act & ~(cs_fld & cfg.chip_select_ack_source))
                || cyc.emul_mem || cyc.background)) e_ack = 0;
            else if (!present) e_ack = 1;
            else if (cfg.ack_interlock) e_ack = !ack_n;
            else e_ack = (cyc.emul_mem || cyc.background) ? 1 : !ack_n;
            ack_ok = !(cyc.background && !cfg.drive_bg);
            e_pin = cfg.shared_pin_function ? 0 : port_bit;
            e_lvl = cfg.interrupt_input_mode ? 0 : {~top, ~mid, ~low};
            e_ded = 0;
            if (cfg.interrupt_input_mode) begin
                e_ded = {1'b0, ~mid, ~low};
                if (!cfg.top_request_trigger_mode) e_ded += (top ? 0 : 4);
                else if (th.size() > 0 && th[th.size()-1] == 1 && top == 0) e_ded += 4;
            end
            th.push_back(top);
            if (th.size() > 2) void'(th.pop_front());
            if (quiet > 0) quiet--;
            hold = rel ? 0 : ((strobe && cfg.clk_internal) ? 1 : hold);
            valid = 1;
        end
    end

    // Compare registered results once settled; space, address and write only when driven, acks and fault only when active
    always @(negedge core_clk_in) begin
        if (valid && !rst_in) begin
            check(emu_rst, hold);
            check(drv, e_drv);
            if (e_drv) begin
                check(space, e_sp);
                check(addr, e_ad);
                check(wr, e_wr);
            end
            if (e_act) begin
                check(oe, e_oe);
                check(cpu_flt, e_flt);
                if (ack_ok) check(cpu_ack, e_ack);
                if (!e_oe) check(ack_out, 0);
            end
            check(pin, e_pin);
            check(lvl, e_lvl);
            if (quiet == 0) check(ded, e_ded);
        end
    end

    // ------------------------------
    // Main sequence
    // ------------------------------
    initial begin
        repeat (4) @(posedge core_clk_in);
        rst_in <= 1'b0;
        @(posedge core_clk_in);
        cfg.clk_internal <= 1'b1;
        strobe <= 1'b1;
        repeat (3) @(posedge core_clk_in);
        strobe <= 1'b0;
        toggles = 0;
        prev_clk = emu_clk;
        repeat (60) begin
            @(posedge core_clk_in);
            #1 if (emu_clk !== prev_clk) toggles++;
            prev_clk = emu_clk;
        end
        check(toggles >= 14 && toggles <= 16, 1);
        rel <= 1'b1;
        cfg.clk_internal <= 1'b0;
        @(posedge core_clk_in);
        rel <= 1'b0;
        strobe <= 1'b1;
        @(posedge core_clk_in);
        strobe <= 1'b0;
        repeat (20) @(negedge core_clk_in) check(emu_clk, probe_clk);
        for (int ph = 0; ph < 24; ph++) begin
            @(posedge core_clk_in);
            seed = lfsr(seed);
            r = seed;
            cfg <= etb_cfg_t'({etb_bg_code_t'(ph[1:0]), r[7:0], r[8], r[9], r[10], 1'b0,
                r[11], r[12], r[13], r[17:14]});
            quiet = 3;
            slow <= r[18];
            repeat (32) begin
                @(posedge core_clk_in);
                seed = lfsr(seed);
                r = seed;
                cyc <= etb_cycle_t'({r[0], r[1], r[2] & ~r[1], r[3], 1'b0, r[4], r[7:5],
                    r[15:8]});
                cs_act <= r[0] ? r[19:16] : 4'h0;
                cs_fld <= r[23:20];
                present <= r[24] | r[25];
                fault <= r[26] & r[27];
                port_bit <= r[28];
                top_ack <= r[29];
                top <= r[30];
                mid <= r[31];
                low <= r[9];
            end
        end
        repeat (3) @(posedge core_clk_in);
        complete_run();
    end
endmodule
`default_nettype wire
